// file: shared/sbrg_pkg.sv
package sbrg_pkg;
	// Register indices on the AXI4-Lite slave
	localparam logic [7:0] POWER_CONTROL_OFS = 8'h87;
	localparam logic [7:0] SERIAL_CONTROL_OFS = 8'h98;
	localparam logic [7:0] TIMER1_RELOAD_OFS = 8'h8c;
	localparam logic [7:0] TIMER2_RELOAD_LOW_OFS = 8'hca;
	localparam logic [7:0] TIMER2_RELOAD_HIGH_OFS = 8'hcb;
	localparam logic [7:0] BAUD_CTRL_OFS = 8'hc8;
	localparam logic [7:0] BAUD_STATUS_OFS = 8'hcc;
	// Byte addresses derived as four times the index
	localparam logic [9:0] POWER_CONTROL_ADDR = {POWER_CONTROL_OFS, 2'b00};
	localparam logic [9:0] SERIAL_CONTROL_ADDR = {SERIAL_CONTROL_OFS, 2'b00};
	localparam logic [9:0] TIMER1_RELOAD_ADDR = {TIMER1_RELOAD_OFS, 2'b00};
	localparam logic [9:0] TIMER2_RELOAD_LOW_ADDR = {TIMER2_RELOAD_LOW_OFS, 2'b00};
	localparam logic [9:0] TIMER2_RELOAD_HIGH_ADDR = {TIMER2_RELOAD_HIGH_OFS, 2'b00};
	localparam logic [9:0] BAUD_CTRL_ADDR = {BAUD_CTRL_OFS, 2'b00};
	localparam logic [9:0] BAUD_STATUS_ADDR = {BAUD_STATUS_OFS, 2'b00};
	// Field positions
	localparam int BAUD_DOUBLE_BIT = 7;
	localparam int MODE_HI_BIT = 7;
	localparam int MODE_LO_BIT = 6;
	localparam int T2_BAUD_MODE_BIT = 0;
	localparam int T2_EXT_CLK_BIT = 1;
	localparam int T1_RUN_BIT = 2;
	localparam int T2_SELECT_BIT = 3;
	// Reset values
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
	localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
	// Division figures
	localparam logic [3:0] MODE0_DIV = 4'hc;
	localparam logic [3:0] T1_PRESCALE = 4'hc;
	localparam logic [5:0] T1_BIT_DIV = 6'h20;
	localparam logic [5:0] MODE2_DIV_SLOW = 6'h40;
	localparam logic [5:0] MODE2_DIV_FAST = 6'h20;
	localparam logic [4:0] T2_BIT_DIV = 5'h10;
	localparam logic [1:0] T2_INT_PRESCALE = 2'h2;
	typedef enum logic [1:0] {
		SBRG_SHIFT_REG,
		SBRG_UART8_VAR,
		SBRG_UART9_FIXED,
		SBRG_UART9_VAR
	} sbrg_mode_t;
	typedef enum logic [1:0] {
		SBRG_RESP_OKAY = 2'h0,
		SBRG_RESP_SLVERR = 2'h2
	} sbrg_resp_t;
endpackage

// file: src/sbrg_core.sv
// Function
// - Mode 0 gives a bit tick every twelve oscillator clocks with no timer involved.
// - Mode 1 takes its rate from Timer 1 or Timer 2 overflow as configured.
// - With Timer 1, rate is K*fosc/(384*(256-reload byte)), K=2 when doubling set.
// - The doubling bit is bit 7 of the power control register at 87H.
// - Timer 2 clocked from its external pin gives the overflow rate divided by 16.
// - Timer 2 clocked internally gives fosc/(32*(65536-reload pair)).
// - Mode 2 rate is fosc/32 with doubling set and fosc/64 with it clear.
// - Mode 2 uses no timer, only the internal phase-2 clock.
// - Mode 3 selects and generates its rate exactly as mode 1.
// - Mode bits 00..11 select shift register, 8-bit UART, 9-bit fixed, 9-bit variable.
module sbrg_core #(
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer 2 external clock, already synchronous
	input wire logic timer2_ext_clock_pin,
	// Serial side
	output logic baud_tick,
	output logic [1:0] serial_mode,
	output logic multiproc_enable
);
	initial begin
		if (ADDR_W < 10) begin
			$error("ADDR_W must be at least 10");
		end
	end

	logic [7:0] power_control_q, serial_control_q, t1_reload_q, t2_low_q, t2_high_q, ctrl_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic tick_q;

	function automatic logic map_hit(input logic [ADDR_W-1:0] a);
		logic [9:0] w;
		w = a[9:0];
		return (a[1:0] == 2'b00) && ((a >> 10) == '0) &&
			(w == sbrg_pkg::POWER_CONTROL_ADDR || w == sbrg_pkg::SERIAL_CONTROL_ADDR ||
			w == sbrg_pkg::TIMER1_RELOAD_ADDR || w == sbrg_pkg::TIMER2_RELOAD_LOW_ADDR ||
			w == sbrg_pkg::TIMER2_RELOAD_HIGH_ADDR || w == sbrg_pkg::BAUD_CTRL_ADDR ||
			w == sbrg_pkg::BAUD_STATUS_ADDR);
	endfunction

	// Write path: address and data taken in either order
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
	wire wr_fire = (aw_have_q || aw_take) && (w_have_q || w_take);
	wire [7:0] wr_byte = w_take ? s_axi_wdata[7:0] : wdata_q;
	wire wr_strb = w_take ? s_axi_wstrb[0] : wstrb0_q;
	wire wr_hit = map_hit(wr_addr);
	wire [9:0] wr_a = wr_addr[9:0];
	wire wr_en = wr_fire && wr_hit && wr_strb;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			aw_have_q <= wr_fire ? 1'b0 : (aw_have_q || aw_take);
			w_have_q <= wr_fire ? 1'b0 : (w_have_q || w_take);
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? sbrg_pkg::SBRG_RESP_OKAY : sbrg_pkg::SBRG_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Register file; the status register is read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_control_q <= sbrg_pkg::POWER_CONTROL_RST;
			serial_control_q <= sbrg_pkg::SERIAL_CONTROL_RST;
			t1_reload_q <= sbrg_pkg::RELOAD_RST;
			t2_low_q <= sbrg_pkg::RELOAD_RST;
			t2_high_q <= sbrg_pkg::RELOAD_RST;
			ctrl_q <= sbrg_pkg::BAUD_CTRL_RST;
		end else if (wr_en) begin
			if (wr_a == sbrg_pkg::POWER_CONTROL_ADDR) begin
				power_control_q <= wr_byte;
			end
			if (wr_a == sbrg_pkg::SERIAL_CONTROL_ADDR) begin
				serial_control_q <= wr_byte;
			end
			if (wr_a == sbrg_pkg::TIMER1_RELOAD_ADDR) begin
				t1_reload_q <= wr_byte;
			end
			if (wr_a == sbrg_pkg::TIMER2_RELOAD_LOW_ADDR) begin
				t2_low_q <= wr_byte;
			end
			if (wr_a == sbrg_pkg::TIMER2_RELOAD_HIGH_ADDR) begin
				t2_high_q <= wr_byte;
			end
			if (wr_a == sbrg_pkg::BAUD_CTRL_ADDR) begin
				ctrl_q <= wr_byte;
			end
		end
	end

	// Mode decode and rate sources
	wire baud_double = power_control_q[sbrg_pkg::BAUD_DOUBLE_BIT];
	wire [1:0] mode_bits = {serial_control_q[sbrg_pkg::MODE_HI_BIT],
		serial_control_q[sbrg_pkg::MODE_LO_BIT]};
	sbrg_pkg::sbrg_mode_t mode;
	assign mode = sbrg_pkg::sbrg_mode_t'(mode_bits);
	assign serial_mode = mode_bits;
	assign multiproc_enable = serial_control_q[5];
	wire t2_sel = ctrl_q[sbrg_pkg::T2_SELECT_BIT] && ctrl_q[sbrg_pkg::T2_BAUD_MODE_BIT];
	wire t2_ext = ctrl_q[sbrg_pkg::T2_EXT_CLK_BIT];
	wire t1_run = ctrl_q[sbrg_pkg::T1_RUN_BIT];

	logic [3:0] div12_q;
	logic [5:0] ph2_q;
	logic [7:0] t1_q;
	logic [5:0] t1_bit_q;
	logic [15:0] t2_q;
	logic [4:0] t2_bit_q;
	logic t2_pre_q, ext_prev_q;

	// Machine-cycle strobe: one oscillator clock in twelve
	wire cyc12 = (div12_q == sbrg_pkg::MODE0_DIV - 4'h1);
	// Timer 1 in 8-bit auto-reload counts machine cycles
	wire t1_ovf = t1_run && cyc12 && (t1_q == 8'hff);
	// 384 = 12 * 32; doubling halves the post-divider to 16
	wire [5:0] t1_lim = baud_double ? (sbrg_pkg::T1_BIT_DIV >> 1) : sbrg_pkg::T1_BIT_DIV;
	wire t1_tick = t1_ovf && (t1_bit_q == t1_lim - 6'h1);
	// Internal Timer 2 clock is fosc/2, external one counts pin rising edges
	wire t2_inc = t2_ext ? (timer2_ext_clock_pin && !ext_prev_q) : t2_pre_q;
	wire t2_ovf = t2_sel && t2_inc && (t2_q == 16'hffff);
	wire t2_tick = t2_ovf && (t2_bit_q == sbrg_pkg::T2_BIT_DIV - 5'h1);
	// Phase-2 clock divider for mode 2
	wire [5:0] ph2_lim = baud_double ? sbrg_pkg::MODE2_DIV_FAST : sbrg_pkg::MODE2_DIV_SLOW;
	// Exact match: a late switch to the fast rate wraps once rather than firing short
	wire ph2_tick = (ph2_q == ph2_lim - 6'h1);
	wire var_tick = t2_sel ? t2_tick : t1_tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div12_q <= 4'h0;
			ph2_q <= 6'h00;
			t2_pre_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			div12_q <= cyc12 ? 4'h0 : div12_q + 4'h1;
			ph2_q <= ph2_tick ? 6'h00 : ph2_q + 6'h01;
			t2_pre_q <= !t2_pre_q;
			ext_prev_q <= timer2_ext_clock_pin;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t1_q <= 8'h00;
			t1_bit_q <= 6'h00;
		end else begin
			if (t1_run && cyc12) begin
				t1_q <= (t1_q == 8'hff) ? t1_reload_q : t1_q + 8'h01;
			end
			if (t1_ovf) begin
				t1_bit_q <= t1_tick ? 6'h00 : t1_bit_q + 6'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t2_q <= 16'h0000;
			t2_bit_q <= 5'h00;
		end else if (!t2_sel) begin
			// Parked on the reload pair so the first period is not a full 16-bit sweep
			t2_q <= {t2_high_q, t2_low_q};
		end else if (t2_inc) begin
			t2_q <= (t2_q == 16'hffff) ? {t2_high_q, t2_low_q} : t2_q + 16'h0001;
			if (t2_ovf) begin
				t2_bit_q <= t2_tick ? 5'h00 : t2_bit_q + 5'h01;
			end
		end
	end

	// Source selected every cycle from the mode bits
	logic tick_d;
	always_comb begin
		unique case (mode)
			sbrg_pkg::SBRG_SHIFT_REG: tick_d = cyc12;
			sbrg_pkg::SBRG_UART8_VAR: tick_d = var_tick;
			sbrg_pkg::SBRG_UART9_FIXED: tick_d = ph2_tick;
			sbrg_pkg::SBRG_UART9_VAR: tick_d = var_tick;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_d;
		end
	end
	assign baud_tick = tick_q;

	// Read path
	wire ar_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !rvalid_q;
	wire [9:0] rd_a = s_axi_araddr[9:0];
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (rd_a == sbrg_pkg::POWER_CONTROL_ADDR) rd_byte = power_control_q;
		if (rd_a == sbrg_pkg::SERIAL_CONTROL_ADDR) rd_byte = serial_control_q;
		if (rd_a == sbrg_pkg::TIMER1_RELOAD_ADDR) rd_byte = t1_reload_q;
		if (rd_a == sbrg_pkg::TIMER2_RELOAD_LOW_ADDR) rd_byte = t2_low_q;
		if (rd_a == sbrg_pkg::TIMER2_RELOAD_HIGH_ADDR) rd_byte = t2_high_q;
		if (rd_a == sbrg_pkg::BAUD_CTRL_ADDR) rd_byte = ctrl_q;
		if (rd_a == sbrg_pkg::BAUD_STATUS_ADDR) rd_byte = {4'h0, t2_sel, mode_bits, baud_double};
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, map_hit(s_axi_araddr) ? rd_byte : 8'h00};
			rresp_q <= map_hit(s_axi_araddr) ? sbrg_pkg::SBRG_RESP_OKAY :
				sbrg_pkg::SBRG_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Assertions
	chk_mode0_period: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == sbrg_pkg::SBRG_SHIFT_REG && cyc12) |=> ##12 (tick_q || mode != $past(mode, 12)))
		else $error("mode 0 tick period wrong");
	chk_mode2_source: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == sbrg_pkg::SBRG_UART9_FIXED) |=> (tick_q == $past(ph2_tick)))
		else $error("mode 2 tick not from phase clock");
	chk_mode2_fast: assert property (@(posedge aclk) disable iff (!aresetn)
		(baud_double && ph2_tick) |-> (ph2_q == 6'h1f))
		else $error("doubled mode 2 divider wrong");
	chk_mode2_slow: assert property (@(posedge aclk) disable iff (!aresetn)
		(!baud_double && ph2_tick) |-> (ph2_q == 6'h3f))
		else $error("mode 2 divider wrong");
	chk_var_source: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode_bits[0]) |=> (tick_q == $past(t2_sel ? t2_tick : t1_tick)))
		else $error("variable mode source wrong");
	chk_t1_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		t1_ovf |=> (t1_q == $past(t1_reload_q)))
		else $error("timer 1 not reloaded");
	chk_t2_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		t2_ovf |=> (t2_q == {$past(t2_high_q), $past(t2_low_q)}))
		else $error("timer 2 not reloaded");
	chk_double_bit: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_a == sbrg_pkg::POWER_CONTROL_ADDR) |=> (baud_double == $past(wr_byte[7])))
		else $error("doubling bit not stored");
	chk_mode_track: assert property (@(posedge aclk) disable iff (!aresetn)
		serial_mode == serial_control_q[7:6])
		else $error("mode bits mismatch");
	cov_mode0: cover property (@(posedge aclk) mode == sbrg_pkg::SBRG_SHIFT_REG && tick_q);
	cov_t1: cover property (@(posedge aclk) mode == sbrg_pkg::SBRG_UART8_VAR && t1_tick);
	cov_t2: cover property (@(posedge aclk) mode == sbrg_pkg::SBRG_UART9_VAR && t2_tick);
	cov_mode2: cover property (@(posedge aclk) mode == sbrg_pkg::SBRG_UART9_FIXED && tick_q);
endmodule

// file: test/sbrg_serial_peer.sv
module sbrg_serial_peer (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bit clock from the generator
	input wire logic baud_tick,
	// Measured spacing of bit ticks, in aclk cycles, and the number of ticks seen
	output logic [31:0] period_q,
	output logic [31:0] ticks_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] gap_q;
	// Behaves like a receiver that only sees bit boundaries; the gap is its baud
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_q <= 32'h1;
			period_q <= 32'h0;
			ticks_q <= 32'h0;
		end else if (baud_tick) begin
			period_q <= gap_q;
			ticks_q <= ticks_q + 32'h1;
			gap_q <= 32'h1;
		end else begin
			gap_q <= gap_q + 32'h1;
		end
	end
endmodule

// file: test/test_serial_baud_rate_gen.sv
module test_serial_baud_rate_gen;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [9:0] awaddr = 10'h0;
	logic [9:0] araddr = 10'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic t2_pin = 1'b0;
	logic [1:0] pin_div = 2'h0;
	logic awready, wready, bvalid, arready, rvalid, baud_tick, multiproc_enable;
	logic [1:0] bresp, rresp, serial_mode, resp;
	logic [31:0] rdata, rd, period, ticks;
	int mismatches = 0;
	int check_count = 0;
	// Mode, doubling and source per step, with the expected tick spacing
	logic [7:0] sc_tab [9] = '{8'h10, 8'h90, 8'h90, 8'h50, 8'h50, 8'hd0, 8'hf0, 8'hb0, 8'h70};
	logic [7:0] pc_tab [9] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
	logic [7:0] bc_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h0d, 8'h0d, 8'h0f};
	logic [31:0] per_tab [9] = '{32'hc, 32'h40, 32'h20, 32'h180, 32'hc0, 32'hc0, 32'h20, 32'h40,
		32'h40};
	// Timer 1 sweeps up from zero once before its first reload
	int bound_tab [9] = '{2000, 2000, 2000, 6000, 2000, 2000, 2000, 2000, 2000};

	always #2.5 aclk = ~aclk;
	// External Timer 2 clock: a rising edge every four cycles
	always @(posedge aclk) begin
		pin_div <= pin_div + 2'h1;
		t2_pin <= pin_div[1];
	end

	sbrg_core u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.timer2_ext_clock_pin(t2_pin), .baud_tick(baud_tick), .serial_mode(serial_mode),
		.multiproc_enable(multiproc_enable));

	sbrg_serial_peer u_peer (.aclk(aclk), .aresetn(aresetn), .baud_tick(baud_tick),
		.period_q(period), .ticks_q(ticks));

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic timed_out();
		mismatches++;
		$display("[FAIL] %0t wait ran out", $time);
		report_and_stop();
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshakes are sampled mid-cycle, where inputs equal what the next edge sees
	task automatic axi_write(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		int n;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			if (tb)
				r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			timed_out();
	endtask

	task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			if (tr) begin
				d = rdata;
				r = rresp;
			end
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			timed_out();
	endtask

	task automatic wait_ticks(input int count, input int bound);
		logic [31:0] start;
		int c;
		start = ticks;
		for (c = 0; c < bound; c++) begin
			@(negedge aclk);
			if (ticks >= start + count)
				break;
		end
		if (c == bound)
			timed_out();
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(sbrg_pkg::POWER_CONTROL_ADDR, rd, resp);
		check(rd, {24'h0, sbrg_pkg::POWER_CONTROL_RST});
		axi_read(sbrg_pkg::SERIAL_CONTROL_ADDR, rd, resp);
		check(rd, {24'h0, sbrg_pkg::SERIAL_CONTROL_RST});
		axi_read(10'h004, rd, resp);
		check({30'h0, resp}, {30'h0, sbrg_pkg::SBRG_RESP_SLVERR});
		check(rd, 32'h0);
		axi_write(10'h004, 8'h55, resp);
		check({30'h0, resp}, {30'h0, sbrg_pkg::SBRG_RESP_SLVERR});
		for (int i = 0; i < 9; i++) begin
			axi_write(sbrg_pkg::SERIAL_CONTROL_ADDR, sc_tab[i], resp);
			axi_write(sbrg_pkg::POWER_CONTROL_ADDR, pc_tab[i], resp);
			axi_write(sbrg_pkg::TIMER1_RELOAD_ADDR, 8'hff, resp);
			axi_write(sbrg_pkg::TIMER2_RELOAD_LOW_ADDR, 8'hff, resp);
			axi_write(sbrg_pkg::TIMER2_RELOAD_HIGH_ADDR, 8'hff, resp);
			axi_write(sbrg_pkg::BAUD_CTRL_ADDR, bc_tab[i], resp);
			check({30'h0, resp}, {30'h0, sbrg_pkg::SBRG_RESP_OKAY});
			axi_read(sbrg_pkg::POWER_CONTROL_ADDR, rd, resp);
			check(rd, {24'h0, pc_tab[i]});
			check({30'h0, serial_mode}, {30'h0, sc_tab[i][7:6]});
			check({31'h0, multiproc_enable}, {31'h0, sc_tab[i][5]});
			wait_ticks(3, bound_tab[i]);
			check(period, per_tab[i]);
		end
		report_and_stop();
	end
endmodule
